// [audio_path_regs.svh]
// register offsets, field positions, reset values and timing counts of the audio path control
`ifndef AUDIO_PATH_REGS_SVH
`define AUDIO_PATH_REGS_SVH

// register byte offsets
`define OFS_CONTROL        8'h00
`define OFS_VOLUME         8'h04
`define OFS_REFERENCE      8'h08
`define OFS_STATUS         8'h0C
`define OFS_FS_DIVIDER     8'h10

// control register field positions
`define CTL_MIC_MODE       0
`define CTL_WIND_FILTER    1
`define CTL_RECORD_MIX     2
`define CTL_BEEP_HP        3
`define CTL_BEEP_SPK       4
`define CTL_LINE_IN        5
`define CTL_THROUGH_LSB    6
`define CTL_THROUGH_MSB    7
`define CTL_LO_GAIN_LSB    8
`define CTL_LO_GAIN_MSB    9
`define CTL_LO_MUTE        10
`define CTL_LO_POWER       11
`define CTL_SPK_POWER      12
`define CTL_HP_POWER       13
`define CTL_NOISE_DEC      14
`define CONTROL_WIDTH      15

// reset values
`define CONTROL_RESET      15'h0E00
`define VOLUME_TOP         5'h1F
`define REFERENCE_RESET    7'h60

// timing
`define HCLK_HZ            125000000
`define FS_HZ              48000
`define FS_DIV_RESET       (`HCLK_HZ / `FS_HZ)
`define CROSSING_TIMEOUT   10'd512
`define ND_DROP_COUNT      7
`define ND_DROP_STEPS      7'd7
`define ND_DOWN_TIME_MS    8000
`define ND_UP_TIME_MS      3000
`define ND_DOWN_FS         ((`ND_DOWN_TIME_MS * `FS_HZ) / (1000 * `ND_DROP_COUNT))
`define ND_UP_FS           ((`ND_UP_TIME_MS * `FS_HZ) / (1000 * `ND_DROP_COUNT))

`endif

// [audio_path_pkg.sv]
// types shared by the audio path control modules
package audio_path_pkg;

  // recovery reference stepping state
  typedef enum logic [2:0] {
    REF_HOLD  = 3'b001,
    REF_LOWER = 3'b010,
    REF_RAISE = 3'b100
  } ref_step_state_t;

endpackage

// [ref_stepper.sv]
// steps the limiter recovery reference toward its target, one step per zero crossing once the pacing interval has passed
`timescale 1ns/100ps
`default_nettype none
`include "audio_path_regs.svh"

module ref_stepper #(
  parameter logic [16:0] DOWN_FS = 17'(`ND_DOWN_FS),
  parameter logic [16:0] UP_FS   = 17'(`ND_UP_FS)
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       clear,
  input  wire logic       fs_tick,
  input  wire logic       crossing,
  input  wire logic       nd_active,
  input  wire logic [6:0] programmed_ref,
  output var  logic [6:0] current_ref,
  output var  logic       moving
);

  audio_path_pkg::ref_step_state_t state_reg;
  audio_path_pkg::ref_step_state_t state_next;
  logic [16:0] interval_reg;
  logic        armed_reg;
  logic [6:0]  target;
  logic [16:0] interval_len;
  logic        step_now;

  // lowered target saturates at the bottom code
  assign target = !nd_active ? programmed_ref :
                  (programmed_ref > `ND_DROP_STEPS) ? programmed_ref - `ND_DROP_STEPS : 7'h00;
  assign interval_len = nd_active ? DOWN_FS : UP_FS;
  assign step_now = armed_reg && crossing && (state_reg != audio_path_pkg::REF_HOLD);

  // direction of travel
  always_comb begin
    case (1'b1)
      (current_ref > target): state_next = audio_path_pkg::REF_LOWER;
      (current_ref < target): state_next = audio_path_pkg::REF_RAISE;
      default:                state_next = audio_path_pkg::REF_HOLD;
    endcase
  end

  // pacing timer: a step needs the interval to pass and then a crossing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interval_reg <= 17'h00000;
      armed_reg    <= 1'b0;
    end else if (clear || state_reg == audio_path_pkg::REF_HOLD || step_now) begin
      interval_reg <= 17'h00000;
      armed_reg    <= 1'b0;
    end else if (fs_tick && !armed_reg) begin
      interval_reg <= interval_reg + 17'h00001;
      armed_reg    <= (interval_reg + 17'h00001 >= interval_len);
    end
  end

  // single steps only outside a clear, which reloads the reset value, so the gain never jumps audibly while stepping
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      current_ref <= `REFERENCE_RESET;
      state_reg   <= audio_path_pkg::REF_HOLD;
    end else if (clear) begin
      current_ref <= `REFERENCE_RESET;
      state_reg   <= audio_path_pkg::REF_HOLD;
    end else begin
      state_reg <= state_next;
      case (state_reg)
        audio_path_pkg::REF_LOWER: if (step_now) current_ref <= current_ref - 7'h01;
        audio_path_pkg::REF_RAISE: if (step_now) current_ref <= current_ref + 7'h01;
        default: current_ref <= current_ref;
      endcase
    end
  end

  assign moving = (state_reg != audio_path_pkg::REF_HOLD);

endmodule
`default_nettype wire

// [audio_path_volume_control.sv]
// analog path control: output volume, routing switches, line output and noise decrease
`timescale 1ns/100ps
`default_nettype none
`include "audio_path_regs.svh"

module audio_path_volume_control #(
  parameter logic [16:0] ND_DOWN_FS = 17'(`ND_DOWN_FS),
  parameter logic [16:0] ND_UP_FS   = 17'(`ND_UP_FS)
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        mute_pin,
  input  wire logic        noise_decrease_pin,
  input  wire logic        power_down_pin,
  input  wire logic        zc_left_sign,
  input  wire logic        zc_right_sign,
  input  wire logic        fade_request,
  input  wire logic [6:0]  current_input_gain,
  output var  logic [5:0]  left_volume_atten,
  output var  logic        left_volume_mute,
  output var  logic [5:0]  right_volume_atten,
  output var  logic        right_volume_mute,
  output var  logic        volume_power,
  output var  logic        volume_switch,
  output var  logic        outputs_to_common,
  output var  logic        mic_internal_path,
  output var  logic        mic_supply_enable,
  output var  logic        wind_filter_on,
  output var  logic        record_mix_switch,
  output var  logic        hp_beep_switch,
  output var  logic        spk_beep_switch,
  output var  logic        speaker_limiter_switch,
  output var  logic        line_input_select,
  output var  logic [1:0]  through_path_switch,
  output var  logic [1:0]  lineout_gain,
  output var  logic        lineout_power_save,
  output var  logic        lineout_high_z,
  output var  logic [6:0]  limiter_reference,
  output var  logic [6:0]  fade_start_code
);

  localparam int PINS = 5;

  // address match, used by every write enable
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  // five-bit code to dB of attenuation: 1 dB, 2 dB, then 4 dB steps
  function automatic logic [5:0] volume_atten(input logic [4:0] code);
    if (code >= 5'h10)
      volume_atten = 6'(5'h1F - code);
    else if (code >= 5'h05)
      volume_atten = 6'h10 + 6'({5'h0F - code, 1'b0});
    else if (code != 5'h00)
      volume_atten = 6'h26 + 6'({5'h04 - code, 2'b00});
    else
      volume_atten = 6'h00;
  endfunction

  // ---------------- pin synchronisers ----------------
  logic [PINS-1:0] pin_raw;
  logic [PINS-1:0] sync_a_reg;
  logic [PINS-1:0] sync_b_reg;
  logic [PINS-1:0] sync_c_reg;
  logic [PINS-1:0] pin_reg;

  assign pin_raw = {zc_right_sign, zc_left_sign, power_down_pin, noise_decrease_pin, mute_pin};

  // three flops; a change counts once the last two agree
  genvar p;
  generate
    for (p = 0; p < PINS; p++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync_a_reg[p] <= 1'b0;
          sync_b_reg[p] <= 1'b0;
          sync_c_reg[p] <= 1'b0;
          pin_reg[p]    <= 1'b0;
        end else begin
          sync_a_reg[p] <= pin_raw[p];
          sync_b_reg[p] <= sync_a_reg[p];
          sync_c_reg[p] <= sync_b_reg[p];
          if (sync_b_reg[p] == sync_c_reg[p]) pin_reg[p] <= sync_c_reg[p];
        end
      end
    end
  endgenerate

  logic mute_active;
  logic pd_low;
  logic [1:0] zc_sign;
  assign mute_active = pin_reg[0];
  assign pd_low      = !pin_reg[2];
  assign zc_sign     = pin_reg[4:3];

  // ---------------- AHB-Lite slave ----------------
  logic        addr_valid;
  logic        wr_pending_reg;
  logic [7:0]  wr_addr_reg;
  logic        wr_control;
  logic        wr_volume;
  logic        wr_reference;
  logic        wr_fs_div;
  logic [31:0] read_word;

  logic [`CONTROL_WIDTH-1:0] control_reg;
  logic [4:0]  volume_code_reg;
  logic [6:0]  reference_reg;
  logic [15:0] fs_div_reg;
  logic [4:0]  applied_reg [2];
  logic [1:0]  pending_reg;
  logic        nd_active;
  logic        ref_moving;

  // only whole-word transfers take effect; others complete as no-ops
  assign addr_valid   = hsel && htrans[1] && hready && (hsize == 3'b010);
  assign wr_control   = wr_pending_reg && reg_hit(wr_addr_reg, `OFS_CONTROL);
  assign wr_volume    = wr_pending_reg && reg_hit(wr_addr_reg, `OFS_VOLUME) && !pd_low;
  assign wr_reference = wr_pending_reg && reg_hit(wr_addr_reg, `OFS_REFERENCE);
  assign wr_fs_div    = wr_pending_reg && reg_hit(wr_addr_reg, `OFS_FS_DIVIDER);

  // read mux; unmapped offsets read zero
  always_comb begin
    case (haddr[7:0])
      `OFS_CONTROL:    read_word = {17'h00000, control_reg};
      `OFS_VOLUME:     read_word = {27'h0000000, volume_code_reg};
      `OFS_REFERENCE:  read_word = {25'h0000000, reference_reg};
      `OFS_STATUS:     read_word = {4'h0, ref_moving, nd_active, pending_reg, 1'b0,
                                    limiter_reference, 3'h0, applied_reg[1], 3'h0, applied_reg[0]};
      `OFS_FS_DIVIDER: read_word = {16'h0000, fs_div_reg};
      default:         read_word = 32'h00000000;
    endcase
  end

  // zero wait states: read data registered from the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending_reg <= 1'b0;
      wr_addr_reg    <= 8'h00;
      hrdata         <= 32'h00000000;
      hreadyout      <= 1'b0;
      hresp          <= 1'b0;
    end else begin
      hreadyout      <= 1'b1;
      hresp          <= 1'b0;
      wr_pending_reg <= addr_valid && hwrite;
      wr_addr_reg    <= haddr[7:0];
      if (addr_valid && !hwrite) hrdata <= read_word;
    end
  end

  // host registers; the power-down pin returns all but the fs divider to reset values
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control_reg     <= `CONTROL_RESET;
      volume_code_reg <= `VOLUME_TOP;
      reference_reg   <= `REFERENCE_RESET;
      fs_div_reg      <= 16'(`FS_DIV_RESET);
    end else if (pd_low) begin
      control_reg     <= `CONTROL_RESET;
      volume_code_reg <= `VOLUME_TOP;
      reference_reg   <= `REFERENCE_RESET;
    end else begin
      if (wr_control)   control_reg     <= hwdata[`CONTROL_WIDTH-1:0];
      if (wr_volume)    volume_code_reg <= hwdata[4:0];
      if (wr_reference) reference_reg   <= hwdata[6:0];
      if (wr_fs_div)    fs_div_reg      <= (hwdata[15:0] == 16'h0000) ? 16'h0001 : hwdata[15:0];
    end
  end

  // ---------------- sample-rate tick ----------------
  logic [15:0] fs_count_reg;
  logic        fs_tick_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fs_count_reg <= 16'h0000;
      fs_tick_reg  <= 1'b0;
    end else begin
      fs_tick_reg  <= (fs_count_reg + 16'h0001 >= fs_div_reg);
      fs_count_reg <= (fs_count_reg + 16'h0001 >= fs_div_reg) ? 16'h0000 : fs_count_reg + 16'h0001;
    end
  end

  // ---------------- zero-crossing volume update ----------------
  logic [1:0] zc_prev_reg;
  logic [1:0] crossing;
  logic [9:0] timeout_count_reg;
  logic       timeout_hit;

  assign crossing    = zc_sign ^ zc_prev_reg;
  assign timeout_hit = fs_tick_reg && (timeout_count_reg == `CROSSING_TIMEOUT - 10'd1);

  // timeout counts sample periods and restarts on each volume write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timeout_count_reg <= 10'h000;
      zc_prev_reg       <= 2'b00;
    end else begin
      zc_prev_reg <= zc_sign;
      if (wr_volume || pd_low || pending_reg == 2'b00)
        timeout_count_reg <= 10'h000;
      else if (fs_tick_reg)
        timeout_count_reg <= timeout_count_reg + 10'h001;
    end
  end

  logic [5:0] atten_reg [2];
  logic [1:0] mute_reg;

  // each channel takes the code on its own crossing or at timeout
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_chan
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          applied_reg[c] <= `VOLUME_TOP;
          pending_reg[c] <= 1'b0;
        end else if (pd_low) begin
          applied_reg[c] <= `VOLUME_TOP;
          pending_reg[c] <= 1'b0;
        end else if (wr_volume) begin
          pending_reg[c] <= 1'b1;
        end else if (pending_reg[c] && (crossing[c] || timeout_hit)) begin
          applied_reg[c] <= volume_code_reg;
          pending_reg[c] <= 1'b0;
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          atten_reg[c] <= 6'h00;
          mute_reg[c]  <= 1'b0;
        end else begin
          atten_reg[c] <= volume_atten(applied_reg[c]);
          mute_reg[c]  <= (applied_reg[c] == 5'h00);
        end
      end
    end
  endgenerate

  assign left_volume_atten  = atten_reg[0];
  assign right_volume_atten = atten_reg[1];
  assign left_volume_mute   = mute_reg[0];
  assign right_volume_mute  = mute_reg[1];

  // ---------------- noise decrease ----------------
  assign nd_active = pin_reg[1] | control_reg[`CTL_NOISE_DEC];

  ref_stepper #(
    .DOWN_FS (ND_DOWN_FS),
    .UP_FS   (ND_UP_FS)
  ) u_ref_stepper (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .clear          (pd_low),
    .fs_tick        (fs_tick_reg),
    .crossing       (|crossing),
    .nd_active      (nd_active),
    .programmed_ref (reference_reg),
    .current_ref    (limiter_reference),
    .moving         (ref_moving)
  );

  // fade starts from the gain in effect, even mid-way through a reference walk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) fade_start_code <= 7'h00;
    else if (fade_request) fade_start_code <= current_input_gain;
  end

  // ---------------- analog switch controls ----------------
  // the mute pin overrides the output-side switches regardless of host setting; record mix, mic and line input follow the host
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      outputs_to_common      <= 1'b0;
      volume_power           <= 1'b0;
      volume_switch          <= 1'b0;
      through_path_switch    <= 2'b00;
      hp_beep_switch         <= 1'b0;
      spk_beep_switch        <= 1'b0;
      speaker_limiter_switch <= 1'b0;
      record_mix_switch      <= 1'b0;
      mic_internal_path      <= 1'b0;
      mic_supply_enable      <= 1'b0;
      wind_filter_on         <= 1'b0;
      line_input_select      <= 1'b0;
      lineout_gain           <= 2'b00;
      lineout_power_save     <= 1'b0;
      lineout_high_z         <= 1'b1;
    end else begin
      outputs_to_common      <= mute_active;
      volume_power           <= control_reg[`CTL_SPK_POWER] | control_reg[`CTL_HP_POWER];
      volume_switch          <= !mute_active;
      through_path_switch    <= mute_active ? 2'b00 :
                                control_reg[`CTL_THROUGH_MSB:`CTL_THROUGH_LSB];
      hp_beep_switch         <= !mute_active && control_reg[`CTL_BEEP_HP];
      spk_beep_switch        <= !mute_active && control_reg[`CTL_BEEP_SPK];
      speaker_limiter_switch <= !mute_active && control_reg[`CTL_SPK_POWER];
      record_mix_switch      <= control_reg[`CTL_RECORD_MIX];
      mic_internal_path      <= control_reg[`CTL_MIC_MODE];
      mic_supply_enable      <= control_reg[`CTL_MIC_MODE];
      wind_filter_on         <= control_reg[`CTL_MIC_MODE] & control_reg[`CTL_WIND_FILTER];
      line_input_select      <= control_reg[`CTL_LINE_IN];
      lineout_gain           <= control_reg[`CTL_LO_GAIN_MSB:`CTL_LO_GAIN_LSB];
      lineout_power_save     <= control_reg[`CTL_LO_MUTE] | mute_active;
      lineout_high_z         <= !control_reg[`CTL_LO_POWER];
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence vol_written;
    wr_volume ##1 (pending_reg == 2'b11);
  endsequence

  sequence left_forced;
    pending_reg[0] && timeout_hit && !wr_volume && !pd_low;
  endsequence

  a_mute_switches_off: assert property (
    mute_active |=> outputs_to_common && !volume_switch && through_path_switch == 2'b00
      && !hp_beep_switch && !spk_beep_switch && !speaker_limiter_switch)
    else $error("mute pin did not force switches off");

  a_mic_supply_gate: assert property (
    !control_reg[`CTL_MIC_MODE] |=> !mic_supply_enable && !wind_filter_on)
    else $error("mic supply or filter active in external mode");

  a_volume_power_on: assert property (
    (control_reg[`CTL_SPK_POWER] || control_reg[`CTL_HP_POWER]) |=> volume_power)
    else $error("volume not powered");

  a_write_restarts_timer: assert property (
    vol_written |-> timeout_count_reg == 10'h000)
    else $error("volume write did not restart timeout");

  a_timeout_applies_left: assert property (
    left_forced |=> !pending_reg[0] && applied_reg[0] == $past(volume_code_reg))
    else $error("timeout did not apply left volume");

  a_left_change_cause: assert property (
    applied_reg[0] != $past(applied_reg[0])
      |-> $past(pd_low) || $past(crossing[0]) || $past(timeout_hit))
    else $error("left volume changed without crossing or timeout");

  a_pd_volume_top: assert property (
    pd_low |=> applied_reg[0] == `VOLUME_TOP && applied_reg[1] == `VOLUME_TOP ##2 !left_volume_mute
      && left_volume_atten == 6'h00)
    else $error("volume not at 0 dB after power-down");

  a_ref_single_step: assert property (
    !pd_low && limiter_reference != $past(limiter_reference)
      |-> $past(|crossing) && (limiter_reference == $past(limiter_reference) + 7'h01
      || limiter_reference == $past(limiter_reference) - 7'h01))
    else $error("reference moved without a single crossing step");

  a_lineout_high_z: assert property (
    !control_reg[`CTL_LO_POWER] |=> lineout_high_z)
    else $error("line output not high impedance when unpowered");

endmodule
`default_nettype wire

// [audio_path_volume_control_tb_top.sv]
// self-checking bench for the audio path volume control
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, ac) begin checks++; if ((ac) !== (ex)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, ac); end end

module audio_path_volume_control_tb_top;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0, through, logain;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, mute = 1'b0, nd_pin = 1'b0, pd_pin = 1'b0;
  logic        zl = 1'b0, zr = 1'b0, fade = 1'b0, lm, rm, vpow, vsw, common;
  logic        micp, mics, wind, rmix, hpb, spb, spklim, linein, lops, lohz;
  logic [6:0]  cig = 7'h00, lref, fstart;
  logic [5:0]  latt, ratt, prev;
  logic [4:0]  codes [8] = '{5'h1F, 5'h1E, 5'h10, 5'h0F, 5'h05, 5'h04, 5'h01, 5'h00};
  logic [15:0] ctl [4] = '{16'h0000, 16'h2002, 16'h1A05, 16'h3FFF};
  logic [13:0] outs [4] = '{14'h0002, 14'h0003, 14'h3411, 14'h3FFD};
  int          checks = 0, n_mismatch = 0;

  audio_path_volume_control #(.ND_DOWN_FS(17'h4), .ND_UP_FS(17'h2)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mute_pin(mute), .noise_decrease_pin(nd_pin),
    .power_down_pin(pd_pin), .zc_left_sign(zl), .zc_right_sign(zr), .fade_request(fade),
    .current_input_gain(cig), .left_volume_atten(latt), .left_volume_mute(lm),
    .right_volume_atten(ratt), .right_volume_mute(rm), .volume_power(vpow),
    .volume_switch(vsw), .outputs_to_common(common), .mic_internal_path(micp),
    .mic_supply_enable(mics), .wind_filter_on(wind), .record_mix_switch(rmix),
    .hp_beep_switch(hpb), .spk_beep_switch(spb), .speaker_limiter_switch(spklim),
    .line_input_select(linein), .through_path_switch(through), .lineout_gain(logain),
    .lineout_power_save(lops), .lineout_high_z(lohz), .limiter_reference(lref),
    .fade_start_code(fstart));

  // 125 MHz bus clock
  always #4 hclk = ~hclk;

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      results();
    end
  endtask

  // one single word transfer; ends with an idle edge so a readback sees new data
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    hsel <= 1'b1;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    hsel <= 1'b0;
    @(posedge hclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    logic [31:0] v;
    bus(a, 1'b0, 32'h0, v);
    `CHK(nm, ex, v)
  endtask

  // sign flips on chosen channels, then time for pin sync and output flop
  task automatic xing(input logic l, input logic r, input int gap);
    if (l) zl <= ~zl;
    if (r) zr <= ~zr;
    repeat (gap) @(posedge hclk);
  endtask

  function automatic logic [5:0] att(input logic [4:0] c);
    if (c >= 5'h10) return 6'(31 - c);
    if (c >= 5'h05) return 6'(16 + 2 * (15 - c));
    if (c != 5'h00) return 6'(38 + 4 * (4 - c));
    return 6'h00;
  endfunction

  // hang guard
  initial begin
    repeat (100000) @(posedge hclk);
    n_mismatch++;
    results();
  end

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    pd_pin <= 1'b1;
    repeat (8) @(posedge hclk);
    rd_chk(8'h00, 32'h0000_0E00, "control");
    rd_chk(8'h04, 32'h0000_001F, "volume");
    rd_chk(8'h14, 32'h0000_0000, "unmapped");
    `CHK("hresp okay", 1'b0, hresp)
    `CHK("left atten", 6'h00, latt)
    `CHK("lineout save", 1'b1, lops)
    wr(8'h10, 32'h0000_0004);
    // volume table boundary codes; no change until a crossing
    prev = 6'h00;
    foreach (codes[i]) begin
      wr(8'h04, {27'h0, codes[i]});
      repeat (8) @(posedge hclk);
      `CHK("held atten", prev, latt)
      xing(1'b1, 1'b1, 8);
      `CHK("left atten", att(codes[i]), latt)
      `CHK("right atten", att(codes[i]), ratt)
      `CHK("left mute", codes[i] == 5'h00, lm)
      prev = att(codes[i]);
    end
    // left crossing only; right waits for 512 samples of 4 cycles
    wr(8'h04, 32'h0000_001A);
    xing(1'b1, 1'b0, 8);
    `CHK("left only", 6'h05, latt)
    `CHK("right pending", 1'b1, rm)
    repeat (1980) @(posedge hclk);
    `CHK("right early", 1'b1, rm)
    repeat (80) @(posedge hclk);
    `CHK("right timeout", 6'h05, ratt)
    `CHK("right unmuted", 1'b0, rm)
    // control bits to switch outputs
    foreach (ctl[i]) begin
      wr(8'h00, {16'h0, ctl[i]});
      repeat (2) @(posedge hclk);
      `CHK("switches", outs[i], {mics, micp, wind, rmix, hpb, spb, linein, through, logain, lops, lohz, vpow})
    end
    `CHK("volume switch", 1'b1, vsw)
    mute <= 1'b1;
    repeat (8) @(posedge hclk);
    `CHK("muted", 7'h03, {vsw, through, hpb, spb, spklim, common, lops})
    mute <= 1'b0;
    repeat (8) @(posedge hclk);
    `CHK("unmuted through", 2'b11, through)
    // noise decrease by bit, release, then by pin
    wr(8'h00, 32'h0000_4000);
    repeat (12) xing(1'b1, 1'b1, 24);
    `CHK("lowered ref", 7'h59, lref)
    wr(8'h00, 32'h0000_0000);
    repeat (12) xing(1'b1, 1'b1, 24);
    `CHK("restored ref", 7'h60, lref)
    nd_pin <= 1'b1;
    repeat (12) xing(1'b0, 1'b1, 24);
    `CHK("pin lowered ref", 7'h59, lref)
    cig <= 7'h2C;
    fade <= 1'b1;
    @(posedge hclk);
    fade <= 1'b0;
    repeat (2) @(posedge hclk);
    `CHK("fade start", 7'h2C, fstart)
    // leave power-down: volume back to 0 dB, line outputs power-save
    pd_pin <= 1'b0;
    repeat (8) @(posedge hclk);
    pd_pin <= 1'b1;
    repeat (8) @(posedge hclk);
    `CHK("pd atten", 6'h00, latt)
    `CHK("pd lineout", 2'b10, {lops, lohz})
    rd_chk(8'h04, 32'h0000_001F, "pd volume");
    results();
  end
endmodule
`default_nettype wire
